// ===== rtl/mfps_top.sv
// motor fault and power mode supervisor: lock checks, supply faults,
// rotor sensing timers, sleep and standby control, driver disable
// assumes inputs synchronous to clk; analog levels arrive pre-compared
// Overview of operation
// - commutate on zero crossings of floating phase
// - missed crossings count raises sync lost event
// - low current past deglitch raises absent motor
// - undervoltage latches or auto clears per mode
// - overvoltage latches or auto clears per mode
// - sensing rise and decay use 12-bit timers
// - rise retries at four clocks then faults
// - decay steps same clocks then faults
// - new pulse during decay raises rate fault
// - mode one selects sleep, everything off
// - mode zero selects standby, supplies stay on
// - standby entry threshold, exit adds hysteresis
// - bus mode scales thresholds by 32767
// - pin low sleeps, pin high wakes, timed
// - bus mode sleeps on zero speed and pin low, timed
// - latched fault holds shutdown until clear, except rate and report-mode lock
// - driver disable pin forces all switches off
// - driver disable raises no fault flag
// - lock mode latch, retry, report, disabled
module mfps_top #(
   parameter int SYNC_W  = 4,
   parameter int DEG_W   = 16,
   parameter int RETRY_W = 24,
   parameter int FRAC_W  = 8
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // commutation
   input  wire logic                 crossing_seen,
   input  wire logic                 crossing_missed,
   input  wire logic [2:0]           floating_phase,
   input  wire logic [SYNC_W-1:0]    sync_miss_limit,
   input  wire logic                 sync_check_enable,
   input  wire logic                 below_current_threshold,
   input  wire logic [DEG_W-1:0]     absent_motor_deglitch_time,
   input  wire logic                 absent_motor_check_enable,
   input  wire logic [3:0]           lock_response_mode,
   input  wire logic [RETRY_W-1:0]   lock_retry_time,
   // supply
   input  wire logic                 supply_below_low_limit,
   input  wire logic                 supply_above_high_limit,
   input  wire logic                 supply_low_response,
   input  wire logic                 supply_high_response,
   input  wire logic                 fault_clear_bit,
   // rotor position sensing
   input  wire logic [1:0]           startup_method,
   input  wire logic                 sensing_pulse_start,
   input  wire logic                 sensing_current_reached,
   input  wire logic                 sensing_current_zero,
   // power modes
   input  wire logic                 device_mode_select,
   input  wire logic                 bus_speed_mode,
   input  wire logic [15:0]          speed_value,
   input  wire logic [15:0]          speed_full_scale,
   input  wire logic [FRAC_W-1:0]    standby_entry_fraction,
   input  wire logic [FRAC_W-1:0]    standby_exit_hysteresis,
   input  wire logic                 speed_pin_low,
   input  wire logic                 speed_pin_high,
   input  wire logic [DEG_W-1:0]     sleep_detect_time,
   input  wire logic [DEG_W-1:0]     wake_detect_time,
   input  wire logic                 driver_disable_pin,
   // outputs
   output logic                      commutate_step,
   output logic [2:0]                sense_phase,
   output logic                      switches_hiz,
   output logic                      supplies_enable,
   output logic                      bus_enable,
   output logic [2:0]                power_state,
   output logic                      fault_indicator_pin_n,
   output mfps_pkg::mfps_flt_t       fault_flags
);
   // ==========================================
   // state
   localparam int TMR_W_L = mfps_pkg::TMR_W;
   typedef struct packed {
      logic [SYNC_W-1:0]  miss_cnt;
      logic [DEG_W-1:0]   deg_cnt;
      logic [RETRY_W-1:0] retry_cnt;
      logic               retrying;
      mfps_pkg::mfps_flt_t flt;
      mfps_pkg::mfps_sn_t sn;
      logic [1:0]         step;
      logic [13:0]        div_cnt;
      logic [TMR_W_L-1:0] tmr;
      mfps_pkg::mfps_pm_t pm;
      logic [DEG_W-1:0]   slp_cnt;
      logic               commute;
      logic [2:0]         phase;
   } mfps_st_t;

   mfps_st_t st_reg;
   mfps_st_t st_next;

   function automatic logic [13:0] step_div(input logic [1:0] s);
      case (s)
         2'h0:    step_div = 14'(mfps_pkg::DIV_0);
         2'h1:    step_div = 14'(mfps_pkg::DIV_1);
         2'h2:    step_div = 14'(mfps_pkg::DIV_2);
         default: step_div = 14'(mfps_pkg::DIV_3);
      endcase
   endfunction

   logic [31:0] entry_lvl;
   logic [31:0] exit_lvl;
   logic        lock_evt;
   logic        lock_protect;
   logic        tick;
   logic        tmr_ovf;
   logic        pin_sleep;

   always_comb
   begin
      if (bus_speed_mode)
      begin
         entry_lvl = (32'(standby_entry_fraction) * 32'(mfps_pkg::SPEED_FS)) >> FRAC_W;
         exit_lvl  = ((32'(standby_entry_fraction) + 32'(standby_exit_hysteresis))
                      * 32'(mfps_pkg::SPEED_FS)) >> FRAC_W;
      end
      else
      begin
         entry_lvl = (32'(standby_entry_fraction) * 32'(speed_full_scale)) >> FRAC_W;
         exit_lvl  = ((32'(standby_entry_fraction) + 32'(standby_exit_hysteresis))
                      * 32'(speed_full_scale)) >> FRAC_W;
      end
   end

   always_comb
   begin
      st_next = st_reg;
      tick    = (st_reg.div_cnt == step_div(st_reg.step) - 14'h0001);
      tmr_ovf = tick && (&st_reg.tmr);
      // ==========================================
      // commutation on floating phase crossings
      st_next.commute = crossing_seen;
      st_next.phase   = floating_phase;
      if (crossing_seen)
         st_next.miss_cnt = '0;
      else if (crossing_missed && st_reg.miss_cnt != sync_miss_limit)
         st_next.miss_cnt = st_reg.miss_cnt + 1'b1;
      if (below_current_threshold && !(&st_reg.deg_cnt))
         st_next.deg_cnt = st_reg.deg_cnt + 1'b1;
      else if (!below_current_threshold)
         st_next.deg_cnt = '0;
      // ==========================================
      // lock events and response
      lock_evt = 1'b0;
      lock_protect = (lock_response_mode[3:2] == mfps_pkg::LOCK_LATCH)
                     || (lock_response_mode[3:2] == mfps_pkg::LOCK_RETRY);
      if (lock_response_mode[3] && lock_response_mode[0])
         lock_protect = 1'b0;
      if (!(lock_response_mode[3] && lock_response_mode[0]))
      begin
         if (sync_check_enable && st_reg.miss_cnt == sync_miss_limit && sync_miss_limit != '0)
         begin
            st_next.flt.sync_lost = 1'b1;
            lock_evt = 1'b1;
         end
         if (absent_motor_check_enable && st_reg.deg_cnt > absent_motor_deglitch_time)
         begin
            st_next.flt.absent_motor = 1'b1;
            lock_evt = 1'b1;
         end
      end
      if (lock_evt)
         st_next.flt.lock = 1'b1;
      if (st_reg.retrying)
      begin
         st_next.retry_cnt = st_reg.retry_cnt + 1'b1;
         if (st_reg.retry_cnt >= lock_retry_time)
         begin
            st_next.retrying = 1'b0;
            st_next.retry_cnt = '0;
            st_next.flt.lock = lock_evt;
            st_next.flt.sync_lost = st_next.flt.sync_lost & lock_evt;
            st_next.flt.absent_motor = st_next.flt.absent_motor & lock_evt;
         end
      end
      else if (lock_evt && lock_response_mode[3:2] == mfps_pkg::LOCK_RETRY)
         st_next.retrying = 1'b1;
      // ==========================================
      // supply faults
      if (supply_below_low_limit)
         st_next.flt.supply_low = 1'b1;
      else if (supply_low_response || fault_clear_bit)
         st_next.flt.supply_low = 1'b0;
      if (supply_above_high_limit)
         st_next.flt.supply_high = 1'b1;
      else if (supply_high_response || fault_clear_bit)
         st_next.flt.supply_high = 1'b0;
      // ==========================================
      // latched lock flags clear only on request with condition gone
      if (fault_clear_bit && !lock_evt && lock_response_mode[3:2] != mfps_pkg::LOCK_RETRY)
      begin
         st_next.flt.lock = 1'b0;
         st_next.flt.sync_lost = 1'b0;
         st_next.flt.absent_motor = 1'b0;
      end
      // ==========================================
      // rotor position sensing
      st_next.div_cnt = tick ? '0 : st_reg.div_cnt + 1'b1;
      if (tick)
         st_next.tmr = st_reg.tmr + 1'b1;
      if (fault_clear_bit)
      begin
         st_next.flt.rise = 1'b0;
         st_next.flt.decay = 1'b0;
         st_next.flt.rate = 1'b0;
      end
      case (st_reg.sn)
         mfps_pkg::SN_IDLE:
            if (sensing_pulse_start && startup_method == mfps_pkg::STARTUP_SENSE)
            begin
               st_next.sn = mfps_pkg::SN_RISE;
               st_next.step = '0;
               st_next.tmr = '0;
               st_next.div_cnt = '0;
            end
         mfps_pkg::SN_RISE:
            if (sensing_current_reached)
            begin
               st_next.sn = mfps_pkg::SN_DECAY;
               st_next.step = '0;
               st_next.tmr = '0;
               st_next.div_cnt = '0;
            end
            else if (tmr_ovf)
            begin
               st_next.tmr = '0;
               st_next.div_cnt = '0;
               if (st_reg.step == mfps_pkg::STEP_LAST)
               begin
                  st_next.flt.rise = 1'b1;
                  st_next.sn = mfps_pkg::SN_IDLE;
               end
               else
                  st_next.step = st_reg.step + 1'b1;
            end
         mfps_pkg::SN_DECAY:
            if (sensing_pulse_start)
            begin
               st_next.flt.rate = 1'b1;
               st_next.sn = mfps_pkg::SN_IDLE;
            end
            else if (sensing_current_zero)
               st_next.sn = mfps_pkg::SN_DONE;
            else if (tmr_ovf)
            begin
               st_next.tmr = '0;
               st_next.div_cnt = '0;
               if (st_reg.step == mfps_pkg::STEP_LAST)
               begin
                  st_next.flt.decay = 1'b1;
                  st_next.sn = mfps_pkg::SN_IDLE;
               end
               else
                  st_next.step = st_reg.step + 1'b1;
            end
         default:
            st_next.sn = mfps_pkg::SN_IDLE;
      endcase
      // ==========================================
      // power modes
      pin_sleep = bus_speed_mode ? (speed_value == 16'h0000 && speed_pin_low) : speed_pin_low;
      if ((st_reg.pm == mfps_pkg::PM_SLEEP) ? speed_pin_high : pin_sleep)
      begin
         if (!(&st_reg.slp_cnt))
            st_next.slp_cnt = st_reg.slp_cnt + 1'b1;
      end
      else
         st_next.slp_cnt = '0;
      case (st_reg.pm)
         mfps_pkg::PM_RUN:
            if (32'(speed_value) < entry_lvl)
               st_next.pm = mfps_pkg::PM_STBY;
         mfps_pkg::PM_STBY:
            if (device_mode_select && st_reg.slp_cnt >= sleep_detect_time)
            begin
               st_next.pm = mfps_pkg::PM_SLEEP;
               st_next.slp_cnt = '0;
            end
            else if (32'(speed_value) > exit_lvl)
               st_next.pm = mfps_pkg::PM_RUN;
         mfps_pkg::PM_SLEEP:
            if (st_reg.slp_cnt >= wake_detect_time)
            begin
               st_next.pm = mfps_pkg::PM_STBY;
               st_next.slp_cnt = '0;
            end
         default:
            st_next.pm = mfps_pkg::PM_STBY;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg <= '0;
         st_reg.sn <= mfps_pkg::SN_IDLE;
         st_reg.pm <= mfps_pkg::PM_STBY;
      end
      else
         st_reg <= st_next;
   end

   // ==========================================
   // outputs
   always_comb
   begin
      commutate_step = st_reg.commute;
      sense_phase = st_reg.phase;
      power_state = st_reg.pm;
      fault_flags = st_reg.flt;
      supplies_enable = (st_reg.pm != mfps_pkg::PM_SLEEP);
      bus_enable = (st_reg.pm != mfps_pkg::PM_SLEEP);
      switches_hiz = driver_disable_pin
                     || st_reg.pm != mfps_pkg::PM_RUN
                     || st_reg.flt.supply_low || st_reg.flt.supply_high
                     || (st_reg.flt.lock && lock_protect)
                     || st_reg.flt.rise || st_reg.flt.decay;
      fault_indicator_pin_n = ~(|st_reg.flt);
   end

   // ==========================================
   // checks
   property p_driver_disable_pin;
      @(posedge clk) disable iff (rst) driver_disable_pin |-> switches_hiz;
   endproperty
   a_driver_disable_pin: assert property (p_driver_disable_pin) else $error("switches on while disabled");
   property p_uv;
      @(posedge clk) disable iff (rst) supply_below_low_limit |=> fault_flags.supply_low && switches_hiz;
   endproperty
   a_uv: assert property (p_uv) else $error("undervoltage not flagged");
   property p_ov;
      @(posedge clk) disable iff (rst) supply_above_high_limit |=> fault_flags.supply_high;
   endproperty
   a_ov: assert property (p_ov) else $error("overvoltage not flagged");
   property p_hold;
      @(posedge clk) disable iff (rst)
         (fault_flags.supply_low && !supply_low_response && !fault_clear_bit) |=> fault_flags.supply_low;
   endproperty
   a_hold: assert property (p_hold) else $error("latched fault dropped");
   property p_sleep_bus;
      @(posedge clk) disable iff (rst)
         $rose(power_state == mfps_pkg::PM_SLEEP) |-> device_mode_select;
   endproperty
   a_sleep_bus: assert property (p_sleep_bus) else $error("sleep without mode");
   property p_sleep_off;
      @(posedge clk) disable iff (rst) power_state == mfps_pkg::PM_SLEEP |-> !supplies_enable && !bus_enable;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("supplies on in sleep");
   property p_stby_on;
      @(posedge clk) disable iff (rst) power_state == mfps_pkg::PM_STBY |-> supplies_enable && bus_enable;
   endproperty
   a_stby_on: assert property (p_stby_on) else $error("supplies off in standby");
   property p_rise;
      @(posedge clk) disable iff (rst) $rose(fault_flags.rise) |-> $past(st_reg.step) == mfps_pkg::STEP_LAST;
   endproperty
   a_rise: assert property (p_rise) else $error("rise fault too early");
   property p_rate;
      @(posedge clk) disable iff (rst)
         (st_reg.sn == mfps_pkg::SN_DECAY && sensing_pulse_start) |=> fault_flags.rate;
   endproperty
   a_rate: assert property (p_rate) else $error("rate fault missing");
endmodule

// ===== rtl/mfps_pkg.sv
// package for the motor fault and power mode supervisor
// assumes a single 20 MHz clock shared by all users
package mfps_pkg;
   // ==========================================
   // timing
   localparam int CLK_HZ          = 20000000;
   localparam int TMR_W           = 12;
   localparam int STEP_HZ_0       = 10000000;
   localparam int STEP_HZ_1       = 1000000;
   localparam int STEP_HZ_2       = 100000;
   localparam int STEP_HZ_3       = 10000;
   localparam int DIV_0           = (CLK_HZ + STEP_HZ_0 - 1) / STEP_HZ_0;
   localparam int DIV_1           = (CLK_HZ + STEP_HZ_1 - 1) / STEP_HZ_1;
   localparam int DIV_2           = (CLK_HZ + STEP_HZ_2 - 1) / STEP_HZ_2;
   localparam int DIV_3           = (CLK_HZ + STEP_HZ_3 - 1) / STEP_HZ_3;
   localparam int SPEED_FS        = 32767;
   localparam logic [1:0] STARTUP_SENSE = 2'h2;
   localparam logic [1:0] STEP_LAST     = 2'h3;
   // ==========================================
   // lock response modes
   localparam logic [1:0] LOCK_LATCH  = 2'h0;
   localparam logic [1:0] LOCK_RETRY  = 2'h1;
   localparam logic [3:0] LOCK_REPORT = 4'h8;
   // ==========================================
   // power mode states
   typedef enum logic [2:0] {
      PM_RUN   = 3'h1,
      PM_STBY  = 3'h2,
      PM_SLEEP = 3'h4
   } mfps_pm_t;
   // sensing phase states
   typedef enum logic [3:0] {
      SN_IDLE  = 4'h1,
      SN_RISE  = 4'h2,
      SN_DECAY = 4'h4,
      SN_DONE  = 4'h8
   } mfps_sn_t;
   // fault flags
   typedef struct packed {
      logic sync_lost;
      logic absent_motor;
      logic lock;
      logic supply_low;
      logic supply_high;
      logic rise;
      logic decay;
      logic rate;
   } mfps_flt_t;
endpackage

// ===== verification/mfps_motor_model.sv
// far-side model: motor phases, back-emf crossings and sensing-pulse current
// assumes the supervisor's clock and reset; bench sets lock and absence
module mfps_motor_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // bench controls
   input  wire logic       locked,
   input  wire logic       absent,
   input  wire logic       pulse_start,
   // phase side
   output logic            crossing_seen,
   output logic            crossing_missed,
   output logic [2:0]      floating_phase,
   output logic            below_current_threshold,
   output logic            sensing_current_reached,
   output logic            sensing_current_zero
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] div_reg;
   logic [4:0] pulse_reg;
   // ==========================================
   // crossings every eight cycles, pulse current ramp
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         div_reg        <= 3'h0;
         pulse_reg      <= 5'h00;
         floating_phase <= 3'h1;
      end
      else
      begin
         div_reg <= div_reg + 3'h1;
         if (div_reg == 3'h7)
            floating_phase <= {floating_phase[1:0], floating_phase[2]};
         if (pulse_start)
            pulse_reg <= 5'h01;
         else if (pulse_reg != 5'h00)
            pulse_reg <= (pulse_reg == 5'h14) ? 5'h00 : pulse_reg + 5'h01;
      end
   end
   // a locked rotor has no back-emf, so the crossing is missed
   assign crossing_seen           = (div_reg == 3'h7) && !locked;
   assign crossing_missed         = (div_reg == 3'h7) && locked;
   assign below_current_threshold = absent;
   // rise over cycles 1-5, peak 6-8, decay until back to idle
   assign sensing_current_reached = (pulse_reg >= 5'h06) && (pulse_reg <= 5'h08);
   assign sensing_current_zero    = (pulse_reg == 5'h00);
endmodule

// ===== verification/mfps_tb_top.sv
// bench for the motor fault and power mode supervisor
// assumes the motor model on the phase side; bench drives supply and speed
module mfps_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0]  F_SYNC = 8'h80, F_ABS = 8'h40, F_LOCK = 8'h20, F_LO = 8'h10, F_HI = 8'h08;
   localparam logic [7:0]  F_SENSE = 8'h07, F_RATE = 8'h01;
   localparam logic [16:0] SP_TAB [9] = '{17'h0012C, 17'h00190, 17'h0012C, 17'h000C8, 17'h10FA0,
                                           17'h111F8, 17'h10CE4, 17'h10C1C, 17'h00190};
   localparam logic [2:0]  ST_TAB [9] = '{3'h2, 3'h1, 3'h1, 3'h2, 3'h2, 3'h1, 3'h1, 3'h2, 3'h1};
   localparam logic [3:0]  LK_TAB [4] = '{4'h0, 4'h4, 4'h8, 4'h9};
   logic        clk = 1'b0, rst = 1'b1, locked = 1'b0, absent = 1'b0, pulse_start = 1'b0;
   logic        sync_check_enable = 1'b1, absent_motor_check_enable = 1'b1, fault_clear_bit = 1'b0;
   logic        supply_lo = 1'b0, supply_hi = 1'b0, lo_resp = 1'b0, hi_resp = 1'b0;
   logic        device_mode_select = 1'b0, bus_speed_mode = 1'b0, driver_disable_pin = 1'b0;
   logic        speed_pin_low = 1'b0, speed_pin_high = 1'b0;
   logic [1:0]  startup_method = 2'h2;
   logic [3:0]  lock_response_mode = 4'h0;
   logic [7:0]  entry_frac = 8'h19, exit_hyst = 8'h0A, mask;
   logic [15:0] speed_value = 16'h0000, speed_full_scale = 16'h0A00;
   logic        crossing_seen, crossing_missed, below_cur, cur_reached, cur_zero, cs_last;
   logic        commutate_step, switches_hiz, supplies_enable, bus_enable, fault_pin_n;
   logic [2:0]  floating_phase, power_state, sense_phase, fp_last;
   mfps_pkg::mfps_flt_t fault_flags;
   int          err_count = 0, num_checks = 0;
   // ==========================================
   // clock, far side and design
   always #25 clk = ~clk;
   mfps_motor_model partner (
      .clk(clk), .rst(rst), .locked(locked), .absent(absent), .pulse_start(pulse_start),
      .crossing_seen(crossing_seen), .crossing_missed(crossing_missed), .floating_phase(floating_phase),
      .below_current_threshold(below_cur), .sensing_current_reached(cur_reached),
      .sensing_current_zero(cur_zero)
   );
   mfps_top dut (
      .clk(clk), .rst(rst), .crossing_seen(crossing_seen), .crossing_missed(crossing_missed),
      .floating_phase(floating_phase), .sync_miss_limit(4'h3), .sync_check_enable(sync_check_enable),
      .below_current_threshold(below_cur), .absent_motor_deglitch_time(16'h000C),
      .absent_motor_check_enable(absent_motor_check_enable), .lock_response_mode(lock_response_mode),
      .lock_retry_time(24'h000014), .supply_below_low_limit(supply_lo), .supply_above_high_limit(supply_hi),
      .supply_low_response(lo_resp), .supply_high_response(hi_resp), .fault_clear_bit(fault_clear_bit),
      .startup_method(startup_method), .sensing_pulse_start(pulse_start),
      .sensing_current_reached(cur_reached), .sensing_current_zero(cur_zero),
      .device_mode_select(device_mode_select), .bus_speed_mode(bus_speed_mode), .speed_value(speed_value),
      .speed_full_scale(speed_full_scale), .standby_entry_fraction(entry_frac),
      .standby_exit_hysteresis(exit_hyst), .speed_pin_low(speed_pin_low), .speed_pin_high(speed_pin_high),
      .sleep_detect_time(16'h000A), .wake_detect_time(16'h000A), .driver_disable_pin(driver_disable_pin),
      .commutate_step(commutate_step), .sense_phase(sense_phase), .switches_hiz(switches_hiz),
      .supplies_enable(supplies_enable), .bus_enable(bus_enable), .power_state(power_state),
      .fault_indicator_pin_n(fault_pin_n), .fault_flags(fault_flags)
   );
   // ==========================================
   // shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      if (err_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic logic [7:0] seen_val(input bit st, input logic [7:0] m);
      return st ? {5'h00, power_state} : (fault_flags & m);
   endfunction
   task automatic wait_for(input bit st, input logic [7:0] m, input logic [7:0] exp, input int bound);
      int i;
      for (i = 0; i < bound && seen_val(st, m) !== exp; i++)
         tick(1);
      check(seen_val(st, m), exp);
      if (seen_val(st, m) !== exp)
         end_of_test();
   endtask
   task automatic clear_faults;
      fault_clear_bit = 1'b1;
      tick(1);
      fault_clear_bit = 1'b0;
   endtask
   // ==========================================
   // main sequence
   initial
   begin
      tick(5);
      check({fault_flags, 5'h00, power_state}, 16'h0002);
      check({switches_hiz, fault_pin_n}, 2'h3);
      tick(5);
      rst = 1'b0;
      for (int k = 0; k < 9; k++)
      begin
         bus_speed_mode = SP_TAB[k][16];
         speed_value = SP_TAB[k][15:0];
         tick(4);
         check(power_state, ST_TAB[k]);
         check({supplies_enable, bus_enable}, 2'h3);
      end
      for (int k = 0; k < 20; k++)
      begin
         cs_last = crossing_seen;
         fp_last = floating_phase;
         tick(1);
         check(commutate_step, cs_last);
         check(sense_phase, fp_last);
      end
      check(switches_hiz, 1'b0);
      driver_disable_pin = 1'b1;
      #1;
      check(switches_hiz, 1'b1);
      tick(3);
      check(switches_hiz, 1'b1);
      driver_disable_pin = 1'b0;
      tick(2);
      check(switches_hiz, 1'b0);
      for (int k = 0; k < 4; k++)
      begin
         lo_resp = k[0];
         hi_resp = k[0];
         mask = k[1] ? F_HI : F_LO;
         supply_hi = k[1];
         supply_lo = !k[1];
         wait_for(0, mask, mask, 4);
         check(fault_pin_n, 1'b0);
         if (!k[0])
         begin
            check(switches_hiz, 1'b1);
            clear_faults();
            tick(2);
            check(fault_flags & mask, mask);
            supply_lo = 1'b0;
            supply_hi = 1'b0;
            tick(3);
            check(fault_flags & mask, mask);
            clear_faults();
         end
         supply_lo = 1'b0;
         supply_hi = 1'b0;
         wait_for(0, mask, 8'h00, 4);
         tick(1);
         check({switches_hiz, fault_pin_n}, 2'h1);
      end
      for (int k = 0; k < 5; k++)
      begin
         lock_response_mode = (k == 4) ? 4'h0 : LK_TAB[k];
         sync_check_enable = (k != 4);
         locked = 1'b1;
         if (k >= 3)
         begin
            tick(60);
            check(fault_flags & (F_SYNC | F_LOCK), 8'h00);
         end
         else
         begin
            wait_for(0, F_SYNC | F_LOCK, F_SYNC | F_LOCK, 60);
            check(switches_hiz, k != 2);
         end
         locked = 1'b0;
         tick(10);
         if (k != 1)
            clear_faults();
         wait_for(0, F_SYNC | F_LOCK, 8'h00, 60);
      end
      sync_check_enable = 1'b1;
      absent = 1'b1;
      tick(6);
      check(fault_flags & F_ABS, 8'h00);
      wait_for(0, F_ABS, F_ABS, 30);
      absent = 1'b0;
      tick(2);
      clear_faults();
      wait_for(0, F_ABS, 8'h00, 8);
      for (int k = 0; k < 3; k++)
      begin
         pulse_start = 1'b1;
         tick(1);
         pulse_start = 1'b0;
         tick(k == 0 ? 40 : 9);
         if (k == 0)
            check(fault_flags & F_SENSE, 8'h00);
      end
      wait_for(0, F_RATE, F_RATE, 4);
      tick(20);
      clear_faults();
      wait_for(0, F_RATE, 8'h00, 4);
      device_mode_select = 1'b1;
      for (int b = 0; b < 2; b++)
      begin
         bus_speed_mode = b[0];
         speed_value = 16'h0000;
         wait_for(1, 8'h00, 8'h02, 8);
         speed_pin_low = 1'b1;
         if (b == 1)
         begin
            speed_value = 16'h0001;
            tick(20);
            check(power_state, 3'h2);
            speed_value = 16'h0000;
         end
         tick(4);
         check(power_state, 3'h2);
         wait_for(1, 8'h00, 8'h04, 30);
         check({supplies_enable, bus_enable}, 2'h0);
         speed_pin_low = 1'b0;
         speed_pin_high = 1'b1;
         tick(4);
         check(power_state, 3'h4);
         wait_for(1, 8'h00, 8'h02, 30);
         speed_pin_high = 1'b0;
      end
      end_of_test();
   end
endmodule
